// >>> rtl/rbfp_defs.vh
// constants for the receive backplane frame pulse selector
`ifndef RBFP_DEFS_VH
`define RBFP_DEFS_VH

// apb register byte addresses
`define RBFP_ADDR_W 12
`define RBFP_CTRL_ADDR 12'h000
`define RBFP_STAT_ADDR 12'h004

// control register fields
`define RBFP_CTRL_W 8
`define RBFP_CTRL_RESET 8'h20
`define RBFP_C_CRC_SEL 0
`define RBFP_C_SIG_SEL 1
`define RBFP_C_OHM_SEL 2
`define RBFP_C_FE 3
`define RBFP_C_INVERT 4
`define RBFP_C_DIR 5
`define RBFP_C_E1 6
`define RBFP_C_ESF 7

// status register fields
`define RBFP_S_BIT_LSB 0
`define RBFP_S_CRC_LSB 8
`define RBFP_S_SIG_LSB 12
`define RBFP_S_T1F_LSB 16
`define RBFP_S_LEVEL 24
`define RBFP_S_PIN_IN 25

// frame geometry, bit indices count from zero
`define RBFP_E1_LAST_BIT 8'hff
`define RBFP_T1_LAST_BIT 8'hc0
`define RBFP_SF_LAST_FRM 5'h0b
`define RBFP_ESF_LAST_FRM 5'h17
`define RBFP_TS0_LAST_BIT 8'h07
`define RBFP_TS16_FIRST_BIT 8'h80
`define RBFP_TS16_LAST_BIT 8'h87

`endif

// >>> rtl/rbfp_pos.v
// bit, frame and multiframe position counters for the backplane stream
`timescale 1ns/1ps
`include "rbfp_defs.vh"
module rbfp_pos (
    input wire clk,
    input wire rst_n,
    input wire adv,
    input wire e1_mode,
    input wire esf_mode,
    input wire frm_align,
    input wire cmf_align,
    input wire smf_align,
    output reg [7:0] bit_cnt,
    output reg [3:0] crc_frm,
    output reg [3:0] sig_frm,
    output reg [4:0] t1_frm
);
    wire [7:0] last_bit;
    wire [4:0] last_t1;
    wire wrap;

    assign last_bit = e1_mode ? `RBFP_E1_LAST_BIT : `RBFP_T1_LAST_BIT;
    assign last_t1 = esf_mode ? `RBFP_ESF_LAST_FRM : `RBFP_SF_LAST_FRM;
    // a framer alignment forces the next bit to be bit 1 of a frame
    assign wrap = frm_align | (bit_cnt == last_bit);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 8'h00;
            crc_frm <= 4'h0;
            sig_frm <= 4'h0;
            t1_frm <= 5'h00;
        end else if (adv) begin
            if (wrap) begin
                bit_cnt <= 8'h00;
                // 16-frame counters keep running when multiframing is off
                crc_frm <= cmf_align ? 4'h0 : crc_frm + 4'h1;
                sig_frm <= smf_align ? 4'h0 : sig_frm + 4'h1;
                if (smf_align || t1_frm >= last_t1) begin
                    t1_frm <= 5'h00;
                end else begin
                    t1_frm <= t1_frm + 5'h01;
                end
            end else begin
                bit_cnt <= bit_cnt + 8'h01;
            end
        end
    end
endmodule

// >>> rtl/rbfp_sync.v
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module rbfp_sync #(
    parameter WIDTH = 2
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// >>> rtl/rbfp_top.v
// receive backplane frame pulse selector with apb control
//
// Behaviour
// - selector bits shape the pulse only while frame pulse direction is output
// - in T1 only the signaling multiframe selector matters
// - T1 signaling selector set: pulse on first framing bit of superframe
// - T1 signaling selector clear: pulse on every framing bit, each 193 bits
// - E1 all selectors clear: one-cycle pulse on bit 1 of each frame
// - E1 crc selector only: pulse at bit 1, frame 1 of crc multiframe
// - E1 signaling selector only: pulse at bit 1, frame 1 of signaling multiframe
// - E1 composite: rise at signaling multiframe start, fall after crc start bit
// - coincident composite alignments give a single one-cycle pulse
// - E1 overhead selector: high across time slots 0 and 16
// - direction 0 drives the pin, direction 1 leaves it as input
// - invert clear gives active high, invert set gives active low
`timescale 1ns/1ps
`include "rbfp_defs.vh"
module rbfp_top (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire backplane_clock_pin,
    input wire frm_align,
    input wire cmf_align,
    input wire smf_align,
    input wire backplane_frame_pulse_in,
    output reg backplane_frame_pulse_out,
    output reg backplane_frame_pulse_oe
);
    reg rst_meta;
    reg rst_n;
    reg [`RBFP_CTRL_W-1:0] ctrl;
    reg clk_prev;
    reg frm_pend;
    reg cmf_pend;
    reg smf_pend;
    reg level;
    reg next_level;
    reg cmf_bit1_now;
    wire [1:0] pin_sync;
    wire clk_s;
    wire fp_in_s;
    wire adv;
    wire [7:0] bit_cnt;
    wire [3:0] crc_frm;
    wire [3:0] sig_frm;
    wire [4:0] t1_frm;
    wire [7:0] n_bit;
    wire [3:0] n_crc;
    wire [3:0] n_sig;
    wire [4:0] n_t1;
    wire [7:0] last_bit;
    wire [4:0] last_t1;
    wire n_wrap;
    wire access;
    wire [31:0] status;

    // reset release through two flops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    rbfp_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({backplane_frame_pulse_in, backplane_clock_pin}),
        .sync_out(pin_sync)
    );
    assign clk_s = pin_sync[0];
    assign fp_in_s = pin_sync[1];

    // active edge of the backplane clock: rising when fe set, else falling
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_s;
        end
    end
    assign adv = ctrl[`RBFP_C_FE] ? (clk_s & ~clk_prev) : (~clk_s & clk_prev);

    // framer alignment pulses are held until the next active edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frm_pend <= 1'b0;
            cmf_pend <= 1'b0;
            smf_pend <= 1'b0;
        end else if (adv) begin
            frm_pend <= frm_align;
            cmf_pend <= cmf_align;
            smf_pend <= smf_align;
        end else begin
            frm_pend <= frm_pend | frm_align;
            cmf_pend <= cmf_pend | cmf_align;
            smf_pend <= smf_pend | smf_align;
        end
    end

    rbfp_pos u_pos (
        .clk(clk),
        .rst_n(rst_n),
        .adv(adv),
        .e1_mode(ctrl[`RBFP_C_E1]),
        .esf_mode(ctrl[`RBFP_C_ESF]),
        .frm_align(frm_pend | frm_align),
        .cmf_align(cmf_pend | cmf_align),
        .smf_align(smf_pend | smf_align),
        .bit_cnt(bit_cnt),
        .crc_frm(crc_frm),
        .sig_frm(sig_frm),
        .t1_frm(t1_frm)
    );

    // position the counters will hold after this active edge
    assign last_bit = ctrl[`RBFP_C_E1] ? `RBFP_E1_LAST_BIT : `RBFP_T1_LAST_BIT;
    assign last_t1 = ctrl[`RBFP_C_ESF] ? `RBFP_ESF_LAST_FRM : `RBFP_SF_LAST_FRM;
    assign n_wrap = frm_pend | frm_align | (bit_cnt == last_bit);
    assign n_bit = n_wrap ? 8'h00 : bit_cnt + 8'h01;
    assign n_crc = !n_wrap ? crc_frm : ((cmf_pend | cmf_align) ? 4'h0 : crc_frm + 4'h1);
    assign n_sig = !n_wrap ? sig_frm : ((smf_pend | smf_align) ? 4'h0 : sig_frm + 4'h1);
    assign n_t1 = !n_wrap ? t1_frm :
        (((smf_pend | smf_align) || t1_frm >= last_t1) ? 5'h00 : t1_frm + 5'h01);

    // pulse level for the new position
    always @* begin
        next_level = level;
        if (!ctrl[`RBFP_C_E1]) begin
            // overhead and crc selectors are not looked at in T1
            if (ctrl[`RBFP_C_SIG_SEL]) begin
                next_level = (n_bit == 8'h00) && (n_t1 == 5'h00);
            end else begin
                next_level = (n_bit == 8'h00);
            end
        end else if (ctrl[`RBFP_C_OHM_SEL]) begin
            next_level = (n_bit <= `RBFP_TS0_LAST_BIT) ||
                ((n_bit >= `RBFP_TS16_FIRST_BIT) && (n_bit <= `RBFP_TS16_LAST_BIT));
        end else begin
            case ({ctrl[`RBFP_C_SIG_SEL], ctrl[`RBFP_C_CRC_SEL]})
                2'b00: begin
                    next_level = (n_bit == 8'h00);
                end
                2'b01: begin
                    next_level = (n_bit == 8'h00) && (n_crc == 4'h0);
                end
                2'b10: begin
                    next_level = (n_bit == 8'h00) && (n_sig == 4'h0);
                end
                2'b11: begin
                    // rise wins; the fall comes one edge after the crc start bit
                    if ((n_bit == 8'h00) && (n_sig == 4'h0)) begin
                        next_level = 1'b1;
                    end else if (cmf_bit1_now) begin
                        next_level = 1'b0;
                    end else begin
                        next_level = level;
                    end
                end
                default: begin
                    next_level = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            cmf_bit1_now <= 1'b0;
        end else if (adv) begin
            level <= next_level;
            cmf_bit1_now <= (n_bit == 8'h00) && (n_crc == 4'h0);
        end
    end

    // pin drive: selectors only reach the pin in master direction
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backplane_frame_pulse_oe <= 1'b0;
            backplane_frame_pulse_out <= 1'b0;
        end else begin
            backplane_frame_pulse_oe <= ~ctrl[`RBFP_C_DIR];
            if (ctrl[`RBFP_C_DIR]) begin
                backplane_frame_pulse_out <= 1'b0;
            end else begin
                backplane_frame_pulse_out <= level ^ ctrl[`RBFP_C_INVERT];
            end
        end
    end

    // apb slave: pready rises in the access phase, one wait-free cycle
    assign access = psel & penable & pready;
    assign status = {6'h00,
        fp_in_s ^ ctrl[`RBFP_C_INVERT],
        level,
        3'h0, t1_frm,
        sig_frm,
        crc_frm,
        bit_cnt};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `RBFP_CTRL_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                pslverr <= (paddr != `RBFP_CTRL_ADDR) && (paddr != `RBFP_STAT_ADDR);
                if (paddr == `RBFP_CTRL_ADDR) begin
                    prdata <= {24'h000000, ctrl};
                end else if (paddr == `RBFP_STAT_ADDR) begin
                    prdata <= status;
                end else begin
                    prdata <= 32'h00000000;
                end
            end else begin
                pslverr <= 1'b0;
            end
            if (access && pwrite && (paddr == `RBFP_CTRL_ADDR)) begin
                ctrl <= pwdata[`RBFP_CTRL_W-1:0];
            end
        end
    end
endmodule

// >>> verif/rbfp_bp_partner.sv
// backplane partner: clock source and frame pulse driver in slave direction
`timescale 1ns/1ps
module rbfp_bp_partner (
    input wire backplane_frame_pulse_oe,
    input wire backplane_frame_pulse_out,
    output logic backplane_clock_pin,
    output wire backplane_frame_pulse_in
);
    logic [2:0] n;
    // full-frame clock has no gaps, so it runs free; offset keeps it off clk edges
    initial begin
        backplane_clock_pin = 1'b0;
        n = 3'h0;
        #3;
        forever #80 backplane_clock_pin = ~backplane_clock_pin;
    end
    always @(posedge backplane_clock_pin) n <= n + 3'h1;
    // the partner drives its own pulse whenever the device leaves the pin
    assign backplane_frame_pulse_in = backplane_frame_pulse_oe ? backplane_frame_pulse_out
        : (n == 3'h0);
endmodule

// >>> verif/rbfp_monitor.sv
// checker on the frame pulse selector ports
`timescale 1ns/1ps
module rbfp_monitor (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire backplane_frame_pulse_out,
    input wire backplane_frame_pulse_oe
);
    reg [7:0] ctl;
    reg [6:0] age;
    reg [7:0] cnt;
    wire sat = age == 7'h7f;
    wire act = backplane_frame_pulse_out ^ ctl[4];
    wire one = !ctl[5] && !(ctl[6] && (ctl[2] || ctl[1:0] == 2'h3));
    // active run length, counted only once the settings have settled
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl <= 8'h20;
            age <= 7'h00;
            cnt <= 8'h00;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000) begin
                ctl <= pwdata[7:0];
                age <= 7'h00;
            end else if (!sat) begin
                age <= age + 7'h01;
            end
            cnt <= (act && sat) ? cnt + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ready_one_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_setup_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    err_addr_a: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
        else $error("error flag wrong");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error read not zero");
    ctrl_read_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, ctl})
        else $error("control readback wrong");
    master_oe_a: assert property (sat && !ctl[5] |-> backplane_frame_pulse_oe)
        else $error("pin not driven");
    slave_idle_a: assert property (sat && ctl[5] |-> !backplane_frame_pulse_oe && !backplane_frame_pulse_out)
        else $error("pin driven in slave");
    pulse_width_a: assert property (one |-> cnt <= 8'h10)
        else $error("pulse too long");
    ohm_width_a: assert property (!ctl[5] && ctl[6] && ctl[2] |-> cnt <= 8'h80)
        else $error("overhead mark too long");
    cover property (pslverr);
    cover property (cnt == 8'h80);
    cover property ($rose(backplane_frame_pulse_oe));
endmodule

bind rbfp_top rbfp_monitor u_rbfp_monitor (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .backplane_frame_pulse_out, .backplane_frame_pulse_oe);

// >>> verif/tb_rbfp_top.sv
// self-checking bench for the backplane frame pulse selector
`timescale 1ns/1ps
module tb_rbfp_top;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er, lv, comp;
    logic frm_align, cmf_align, smf_align, backplane_clock_pin, backplane_frame_pulse_in;
    logic backplane_frame_pulse_out, backplane_frame_pulse_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] c;
    logic [3:0] ce;
    int n_errors = 0;
    int checks = 0;
    int i, f, b, cf, len;
    // row: crc start in frame 1, crc start in frame 0, control byte
    logic [9:0] rows [10] = '{10'h00d, 10'h08a, 10'h048, 10'h249, 10'h14a,
        10'h24b, 10'h14b, 10'h054, 10'h04f, 10'h068};
    rbfp_top u_rbfp_top (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .backplane_clock_pin, .frm_align, .cmf_align, .smf_align,
        .backplane_frame_pulse_in, .backplane_frame_pulse_out, .backplane_frame_pulse_oe);
    rbfp_bp_partner u_rbfp_bp_partner (.backplane_frame_pulse_oe, .backplane_frame_pulse_out,
        .backplane_clock_pin, .backplane_frame_pulse_in);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task align(input logic sm, input logic cm);
        frm_align <= 1'b1;
        smf_align <= sm;
        cmf_align <= cm;
        @(posedge clk);
        frm_align <= 1'b0;
        smf_align <= 1'b0;
        cmf_align <= 1'b0;
    endtask
    task edge_wait();
        if (c[3]) @(posedge backplane_clock_pin);
        else @(negedge backplane_clock_pin);
    endtask
    task run_row(input logic [9:0] r);
        c = r[7:0];
        cf = r[8] ? 0 : r[9] ? 1 : 2;
        len = c[6] ? 256 : 193;
        comp = 1'b0;
        apb(1'b1, 12'h000, {24'h0, c});
        edge_wait();
        repeat (10) @(posedge clk);
        // one-bit frame with a crc start, so the crc count cannot be 0 by chance in frame 0
        align(1'b0, 1'b1);
        edge_wait();
        repeat (10) @(posedge clk);
        align(1'b1, r[8]);
        for (f = 0; f < 2; f++) begin
            for (b = 0; b < (f ? 8 : len); b++) begin
                edge_wait();
                repeat (12) @(posedge clk);
                comp = (b == 0 && f == 0) || (comp && !(b == 1 && f == cf));
                lv = (c[6] && c[2]) ? (b < 8 || (b >= 128 && b < 136)) :
                    (c[6] && c[1:0] == 2'h3) ? comp :
                    (c[6] && c[0]) ? (b == 0 && f == cf) :
                    c[1] ? (b == 0 && f == 0) : (b == 0);
                chk("pulse", backplane_frame_pulse_out, c[5] ? 1'b0 : lv ^ c[4]);
                chk("drive", backplane_frame_pulse_oe, !c[5]);
                if (f == 0 && b == len - 1)
                    align(1'b0, r[9]);
            end
        end
        // still inside bit 7 of frame 1: status shows the position and the level
        ce = (cf == 1) ? 4'h0 : (cf == 0) ? 4'h1 : 4'h2;
        apb(1'b0, 12'h004, 32'h0);
        chk("status", rd[24:0], {lv, 3'h0, 5'h01, 4'h1, ce, 8'h07});
        if (!c[5])
            chk("pin in", rd[25], lv);
    endtask
    task summarize();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, frm_align, cmf_align, smf_align} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        c = 8'h08;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", rd, 32'h20);
        chk("oe reset", backplane_frame_pulse_oe, 1'b0);
        apb(1'b1, 12'h004, 32'hff);
        chk("status write", er, 1'b0);
        apb(1'b1, 12'h010, 32'h4f);
        chk("unmapped write", er, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped read", rd, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl kept", rd, 32'h20);
        for (i = 0; i < 10; i++)
            run_row(rows[i]);
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
